// ==== logic/tlic_top.sv ====
// line interface control: register, recovery, attenuator, clock select
`timescale 1ns/1ps
module tlic_top
#(
  parameter int unsigned OS_RATIO   = tlic_pkg::OS_RATIO_DEF,
  parameter int unsigned CL_BITS    = 192,
  parameter int unsigned ALT_WINDOW = 256
)
(
  input  wire logic       CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       CS_B_I,
  input  wire logic       RD_B_I,
  input  wire logic       WR_B_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] DATA_I,
  output logic      [7:0] DATA_O,
  output logic            DATA_OE_O,
  input  wire logic       RX_TIP_I,
  input  wire logic       RX_RING_I,
  input  wire logic       ALT_CLK_I,
  input  wire logic       TX_CLK_I,
  input  wire logic       TX_DATA_I,
  output logic            RCLK_O,
  output logic            RDATA_O,
  output logic            CARRIER_LOSS_O,
  output logic            TX_TIP_O,
  output logic            TX_RING_O,
  output logic            TX_OE_O,
  output logic      [2:0] BUILD_OUT_O,
  output logic            EQ_GAIN_LIMIT_O
);

  localparam int OSW = $clog2(OS_RATIO);
  localparam int CLW = $clog2(CL_BITS + 1);
  localparam int AWW = $clog2(ALT_WINDOW);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  tlic_pkg::tlic_pins_s pin_meta;
  tlic_pkg::tlic_pins_s pin_s;
  tlic_pkg::tlic_pins_s pin_d;
  tlic_pkg::tlic_pins_s pin_raw;

  assign pin_raw = '{CS_B_I, RD_B_I, WR_B_I, ADDR_I, DATA_I, RX_TIP_I,
                     RX_RING_I, ALT_CLK_I, TX_CLK_I, TX_DATA_I};

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      pin_meta <= tlic_pkg::PINS_IDLE;
      pin_s    <= tlic_pkg::PINS_IDLE;
      pin_d    <= tlic_pkg::PINS_IDLE;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
      pin_d    <= pin_s;
    end
  end

  // ----------------------------------------------------------------
  // parallel control port
  // ----------------------------------------------------------------
  tlic_pkg::tlic_ctrl_s ctrl;
  logic                 trip;
  logic                 trip_set;
  logic [7:0]           rdata;

  wire wr_done   = pin_s.wr_b && !pin_d.wr_b && !pin_d.cs_b;
  wire rd_act    = !pin_s.cs_b && !pin_s.rd_b;
  wire rd_was    = !pin_d.cs_b && !pin_d.rd_b;
  wire rd_end    = rd_was && !rd_act;
  wire ctrl_wr   = wr_done && pin_d.addr == tlic_pkg::CTRL_ADDR;
  wire trip_clr  = rd_end && pin_d.addr == tlic_pkg::INFO2_ADDR;
  wire sel_ctrl  = pin_s.addr == tlic_pkg::CTRL_ADDR;
  wire sel_info2 = pin_s.addr == tlic_pkg::INFO2_ADDR;
  wire [7:0] info2_val = 8'(trip) << tlic_pkg::INFO2_TRIP_BIT;

  assign rdata = sel_ctrl ? ctrl : (sel_info2 ? info2_val : 8'h00);

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      ctrl      <= tlic_pkg::CTRL_RESET;
      trip      <= 1'b0;
      DATA_O    <= 8'h00;
      DATA_OE_O <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl <= pin_d.wdata;                        // [R17]
      trip      <= trip_set || (trip && !trip_clr); // [R14]
      DATA_O    <= rdata;                           // [R17]
      DATA_OE_O <= rd_act;
    end
  end

  // ----------------------------------------------------------------
  // oversampled clock and data recovery, carrier loss
  // ----------------------------------------------------------------
  logic [OSW-1:0] os_cnt;
  logic           mark_seen;
  logic           rec_stb;
  logic           rec_bit;
  logic           rec_clk;
  logic [CLW-1:0] zero_bits;
  logic           carrier_loss;

  wire mark      = pin_s.rx_tip || pin_s.rx_ring;
  wire mark_rise = mark && !(pin_d.rx_tip || pin_d.rx_ring);
  wire os_wrap   = os_cnt == OSW'(OS_RATIO - 1);

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      os_cnt       <= '0;
      mark_seen    <= 1'b0;
      rec_stb      <= 1'b0;
      rec_bit      <= 1'b0;
      rec_clk      <= 1'b0;
      zero_bits    <= CLW'(CL_BITS);   // [R8]
      carrier_loss <= 1'b1;
    end
    else
    begin
      // realign phase on each mark edge, sample at window end
      os_cnt    <= mark_rise ? OSW'(OS_RATIO / 2) : os_cnt + 1'b1; // [R7]
      mark_seen <= os_wrap ? mark : (mark_seen || mark);
      rec_stb   <= os_wrap;
      rec_clk   <= os_cnt < OSW'(OS_RATIO / 2);    // [R15]
      if (os_wrap)
      begin
        rec_bit <= mark_seen || mark;
        if (mark_seen || mark)
          zero_bits <= '0;
        else if (zero_bits != CLW'(CL_BITS))
          zero_bits <= zero_bits + 1'b1;
      end
      carrier_loss <= zero_bits == CLW'(CL_BITS);  // [R8]
    end
  end

  // ----------------------------------------------------------------
  // alternate clock presence, transmit clock edges
  // ----------------------------------------------------------------
  logic [AWW-1:0] alt_win;
  logic           alt_seen;
  logic           alt_present;
  logic           tx_stb;
  logic           tx_bit;

  wire alt_edge = pin_s.alt_clk != pin_d.alt_clk;
  wire win_end  = alt_win == AWW'(ALT_WINDOW - 1);

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      alt_win     <= '0;
      alt_seen    <= 1'b0;
      alt_present <= 1'b0;
      tx_stb      <= 1'b0;
      tx_bit      <= 1'b0;
    end
    else
    begin
      alt_win  <= alt_win + 1'b1;
      alt_seen <= win_end ? alt_edge : (alt_seen || alt_edge);
      if (win_end)
        alt_present <= alt_seen || alt_edge;       // [R9]
      tx_stb <= pin_s.tx_clk && !pin_d.tx_clk;
      tx_bit <= pin_s.tx_data;
    end
  end

  // ----------------------------------------------------------------
  // jitter attenuator: bit buffer and pulled crystal divider
  // ----------------------------------------------------------------
  logic       mem [tlic_pkg::JA_DEPTH_DEEP];
  logic [6:0] wptr;
  logic [6:0] rptr;
  logic [7:0] fill;
  logic [5:0] div_cnt;
  logic       ja_stb;
  logic       ja_clk;
  logic       ja_bit;
  logic       depth_q;

  wire       ja_on   = !ctrl.jitter_attenuator_disable;       // [R5]
  wire       ja_rx   = ja_on && !ctrl.jitter_path_select;     // [R3]
  wire       ja_tx   = ja_on && ctrl.jitter_path_select;
  wire [7:0] depth   = ctrl.jitter_depth_select ?
                       tlic_pkg::JA_DEPTH_SHAL :
                       tlic_pkg::JA_DEPTH_DEEP;               // [R4]
  wire [7:0] lim     = ctrl.jitter_depth_select ?
                       tlic_pkg::JA_LIM_SHAL :
                       tlic_pkg::JA_LIM_DEEP;
  wire [7:0] centre  = depth >> 1;
  wire [6:0] dmask   = 7'(depth - 8'h01);
  // centred crystal: receive side, loss and no alternate clock
  wire       ja_frz  = !ja_on || (ja_rx && carrier_loss && !alt_present)
                       || depth_q != ctrl.jitter_depth_select; // [R10]
  wire       in_stb  = ja_tx ? tx_stb :
                       (carrier_loss ? alt_edge && pin_s.alt_clk : rec_stb);
  wire       in_bit  = ja_tx ? tx_bit : (rec_bit && !carrier_loss);
  wire       wr_ok   = in_stb && fill < depth && !ja_frz;
  wire       rd_ok   = ja_stb && fill != 8'h00 && !ja_frz;
  wire       hi_trip = fill > centre + (lim >> 1);
  wire       lo_trip = fill < centre - (lim >> 1);
  wire       lim_hit = !ja_frz && (hi_trip || lo_trip);       // [R13]
  logic [5:0] period;

  always_comb
  begin
    if (ja_frz)
      period = tlic_pkg::JA_DIV_NOM;
    else if (lim_hit)
      period = hi_trip ? tlic_pkg::JA_DIV_FAST
                       : tlic_pkg::JA_DIV_SLOW;               // [R14]
    else if (fill > centre)
      period = tlic_pkg::JA_DIV_NOM - tlic_pkg::JA_PULL_STEP; // [R12]
    else if (fill < centre)
      period = tlic_pkg::JA_DIV_NOM + tlic_pkg::JA_PULL_STEP;
    else
      period = tlic_pkg::JA_DIV_NOM;
  end

  assign trip_set = lim_hit;

  always_ff @(posedge CLK_I)
  begin
    if (wr_ok)
      mem[wptr] <= in_bit;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      wptr    <= '0;
      rptr    <= '0;
      fill    <= '0;
      div_cnt <= '0;
      ja_stb  <= 1'b0;
      ja_clk  <= 1'b0;
      ja_bit  <= 1'b0;
      depth_q <= 1'b0;
    end
    else
    begin
      depth_q <= ctrl.jitter_depth_select;
      if (ja_frz)
      begin
        wptr <= 7'(centre);
        rptr <= '0;
        fill <= centre;
      end
      else
      begin
        wptr <= wr_ok ? (wptr + 1'b1) & dmask : wptr;
        rptr <= rd_ok ? (rptr + 1'b1) & dmask : rptr;
        fill <= fill + 8'(wr_ok) - 8'(rd_ok);
      end
      if (rd_ok)
        ja_bit <= mem[rptr];
      div_cnt <= (div_cnt >= period - 1'b1) ? '0 : div_cnt + 1'b1;
      ja_stb  <= div_cnt >= period - 1'b1;
      ja_clk  <= div_cnt < (period >> 1);            // [R15]
    end
  end

  // ----------------------------------------------------------------
  // recovered clock source and transmit line drive
  // ----------------------------------------------------------------
  logic ami_pol;

  wire use_ja_clk = ja_rx || (carrier_loss && !alt_present && ja_on);
  wire next_rclk  = use_ja_clk ? ja_clk :                       // [R10]
                    (carrier_loss ? (alt_present ? pin_s.alt_clk
                                                 : pin_s.tx_clk)
                                  : rec_clk);                   // [R11]
  wire tx_go      = ja_tx ? ja_stb : tx_stb;
  wire tx_off     = ctrl.transmit_power_down;                   // [R6]
  wire tx_one     = (ja_tx ? ja_bit : tx_bit) && !tx_off;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      RCLK_O          <= 1'b0;
      RDATA_O         <= 1'b0;
      CARRIER_LOSS_O  <= 1'b1;
      TX_TIP_O        <= 1'b0;
      TX_RING_O       <= 1'b0;
      TX_OE_O         <= 1'b0;
      BUILD_OUT_O     <= 3'h0;
      EQ_GAIN_LIMIT_O <= 1'b0;
      ami_pol         <= 1'b0;
    end
    else
    begin
      RCLK_O          <= next_rclk;
      RDATA_O         <= ja_rx ? ja_bit : rec_bit;
      CARRIER_LOSS_O  <= carrier_loss;
      TX_OE_O         <= !ctrl.transmit_power_down;  // [R6]
      BUILD_OUT_O     <= ctrl.build_out;             // [R1]
      EQ_GAIN_LIMIT_O <= ctrl.equalizer_gain_limit;  // [R2]
      if (tx_go || tx_off)
      begin
        TX_TIP_O  <= tx_one && !ami_pol;
        TX_RING_O <= tx_one && ami_pol;
        ami_pol   <= ami_pol ^ tx_one;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  ctrl_write_a: assert property // [R17]
    (ctrl_wr |=> ctrl == $past(pin_d.wdata))
    else $error("control register write lost");
  tx_power_a: assert property (ctrl.transmit_power_down |=> !TX_OE_O) // [R6]
    else $error("transmit outputs driven in power down");
  tx_quiet_a: assert property // [R6]
    (ctrl.transmit_power_down |=> !TX_TIP_O && !TX_RING_O)
    else $error("line pulses sent in power down");
  build_out_a: assert property // [R1]
    (##1 BUILD_OUT_O == $past(ctrl.build_out))
    else $error("build-out code not forwarded");
  gain_limit_a: assert property // [R2]
    (ctrl_wr ##1 1 |=> EQ_GAIN_LIMIT_O == $past(pin_d.wdata[4], 2))
    else $error("gain limit not forwarded");
  trip_flag_a: assert property (lim_hit |=> trip) // [R14]
    else $error("trip flag not set at limit");
  trip_div_a: assert property // [R14]
    (lim_hit |-> period == tlic_pkg::JA_DIV_FAST ||
                 period == tlic_pkg::JA_DIV_SLOW)
    else $error("divider not moved at limit");
  fill_depth_a: assert property // [R4]
    (fill <= depth || $changed(ctrl.jitter_depth_select) ||
     $past(ja_frz) != ja_frz || depth_q != ctrl.jitter_depth_select)
    else $error("buffer fill beyond selected depth");
  crystal_a: assert property // [R10]
    (ja_rx && carrier_loss && !alt_present |->
     period == tlic_pkg::JA_DIV_NOM)
    else $error("crystal not centred in loss");
  alt_direct_a: assert property // [R11]
    (!ja_rx && carrier_loss && alt_present |=>
     RCLK_O == $past(pin_s.alt_clk))
    else $error("alternate clock not routed directly");
  loss_set_a: assert property // [R8]
    (zero_bits == CLW'(CL_BITS) |=> carrier_loss ##1 CARRIER_LOSS_O)
    else $error("carrier loss not declared");

  trip_c: cover property (lim_hit ##1 trip_clr);
  loss_c: cover property ($rose(carrier_loss) ##[1:1000] alt_present);
  ctrl_c: cover property (ctrl_wr ##1 ctrl.jitter_path_select);

endmodule : tlic_top

// ==== logic/tlic_pkg.sv ====
// constants and types for the line interface control block
// Notes on behaviour
// R1: build-out code selects DSX-1 range or CSU attenuation
// R2: gain limit bit: 0 gives -36dB, 1 -30dB
// R3: path bit: 0 receive side, 1 transmit side
// R4: depth bit: 0 gives 128 bits, 1 32
// R5: disable bit removes the attenuator from path
// R6: power-down bit tri-states both transmit outputs
// R7: 32x oversampling of PLL clock recovers clock, data
// R8: no marks on receive pair declares carrier loss
// R9: alternate clock presence is sensed continuously
// R10: loss, receive side: alternate via attenuator, else crystal
// R11: loss, transmit side: alternate direct, else transmit clock (code gives the attenuator clock unless the attenuator is disabled)
// R12: crystal divider is pulled to track incoming rate
// R13: limit at 120 UI deep, 28 UI shallow
// R14: on limit divide 3.5 or 4.5, set trip flag
// R15: receive-side attenuator gives near 50% recovered clock
// R16: host should normally set the gain limit bit
// R17: control register host read/write, acts after write
package tlic_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR  = 8'h7C;
  localparam logic [7:0] INFO2_ADDR = 8'h31;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned INFO2_TRIP_BIT = 2;

  typedef struct packed {
    logic [2:0] build_out;
    logic       equalizer_gain_limit;
    logic       jitter_path_select;
    logic       jitter_depth_select;
    logic       jitter_attenuator_disable;
    logic       transmit_power_down;
  } tlic_ctrl_s;

  // ----------------------------------------------------------------
  // pins sampled through the synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cs_b;
    logic       rd_b;
    logic       wr_b;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       rx_tip;
    logic       rx_ring;
    logic       alt_clk;
    logic       tx_clk;
    logic       tx_data;
  } tlic_pins_s;

  localparam logic [23:0] PINS_IDLE = 24'hE00000;

  // ----------------------------------------------------------------
  // timing and attenuator constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned OS_RATIO_DEF  = 32;
  localparam logic [7:0]  JA_DEPTH_DEEP = 8'h80;
  localparam logic [7:0]  JA_DEPTH_SHAL = 8'h20;
  localparam logic [7:0]  JA_LIM_DEEP   = 8'h78;
  localparam logic [7:0]  JA_LIM_SHAL   = 8'h1C;
  // divider periods: nominal /4, limit /3.5 and /4.5 in eighths
  localparam logic [5:0]  JA_DIV_NOM    = 6'h20;
  localparam logic [5:0]  JA_DIV_FAST   = 6'h1C;
  localparam logic [5:0]  JA_DIV_SLOW   = 6'h24;
  localparam logic [5:0]  JA_PULL_STEP  = 6'h01;

endpackage : tlic_pkg

// ==== tb/tlic_line_model.sv ====
// line-side partner: receive marks and alternate clock
`timescale 1ns/1ps
module tlic_line_model
#(
  parameter int unsigned BIT_CLKS = 32
)
(
  input  wire logic clk_i,
  input  wire logic line_on_i,
  input  wire logic alt_on_i,
  output logic      rx_tip_o,
  output logic      rx_ring_o,
  output logic      alt_clk_o
);
  int unsigned phase;
  logic        pol;
  logic [1:0]  adiv;
  initial
  begin
    phase = 0;
    pol = 1'b0;
    adiv = 2'h0;
    rx_tip_o = 1'b0;
    rx_ring_o = 1'b0;
    alt_clk_o = 1'b0;
  end
  always @(posedge clk_i)
  begin
    phase <= (phase == BIT_CLKS - 1) ? 0 : phase + 1;
    // ami mark for a quarter bit, polarity alternating
    rx_tip_o <= line_on_i && phase < BIT_CLKS / 4 && !pol;
    rx_ring_o <= line_on_i && phase < BIT_CLKS / 4 && pol;
    if (phase == BIT_CLKS - 1)
      pol <= !pol;
    adiv <= adiv + 2'h1;
    // absent clock held low, as if tied to ground
    alt_clk_o <= alt_on_i & adiv[1];
  end
endmodule : tlic_line_model

// ==== tb/test_t1_line_interface_control.sv ====
// self-checking bench for the line interface control block
`timescale 1ns/1ps
module test_t1_line_interface_control;
  localparam int unsigned CL_BITS = 4;
  logic clk = 1'b0, rst_b = 1'b0, cs_b = 1'b1, rd_b = 1'b1, wr_b = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, data_o;
  logic tx_clk = 1'b0, tx_data = 1'b0, line_on = 1'b0, alt_on = 1'b0;
  logic data_oe, rx_tip, rx_ring, alt_clk, rclk, rdata, cl, tx_tip;
  logic tx_ring, tx_oe, eq, tip_q = 1'b0, ring_q = 1'b0;
  logic [2:0] bo;
  int num_errors = 0, n_tests = 0, tip_n = 0, ring_n = 0;

  tlic_top #(.OS_RATIO(32), .CL_BITS(CL_BITS), .ALT_WINDOW(16)) i_dut (
    .CLK_I(clk), .RST_B_I(rst_b), .CS_B_I(cs_b), .RD_B_I(rd_b),
    .WR_B_I(wr_b), .ADDR_I(addr), .DATA_I(wdata), .DATA_O(data_o),
    .DATA_OE_O(data_oe), .RX_TIP_I(rx_tip), .RX_RING_I(rx_ring),
    .ALT_CLK_I(alt_clk), .TX_CLK_I(tx_clk), .TX_DATA_I(tx_data),
    .RCLK_O(rclk), .RDATA_O(rdata), .CARRIER_LOSS_O(cl),
    .TX_TIP_O(tx_tip), .TX_RING_O(tx_ring), .TX_OE_O(tx_oe),
    .BUILD_OUT_O(bo), .EQ_GAIN_LIMIT_O(eq));

  tlic_line_model #(.BIT_CLKS(32)) i_line (
    .clk_i(clk), .line_on_i(line_on), .alt_on_i(alt_on),
    .rx_tip_o(rx_tip), .rx_ring_o(rx_ring), .alt_clk_o(alt_clk));

  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tip_q <= tx_tip;
    ring_q <= tx_ring;
    if (tx_tip === 1'b1 && tip_q === 1'b0)
      tip_n++;
    if (tx_ring === 1'b1 && ring_q === 1'b0)
      ring_n++;
  end

  // ------------------------------------------------------------
  // access and check tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    cs_b = 1'b0;
    addr = a;
    wdata = d;
    wr_b = 1'b0;
    tick(4);
    wr_b = 1'b1;
    tick(4);
    cs_b = 1'b1;
    tick(6);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp,
                          input string what);
    int k;
    cs_b = 1'b0;
    rd_b = 1'b0;
    addr = a;
    for (k = 0; k < 10 && data_oe !== 1'b1; k++)
      tick(1);
    chk("read enable", 8'h01, {7'h00, data_oe});
    chk(what, exp, data_o);
    cs_b = 1'b1;
    rd_b = 1'b1;
    tick(6);
  endtask : reg_read

  task automatic wait_cl(input logic lvl, input int bound);
    int k;
    for (k = 0; k < bound && cl !== lvl; k++)
      tick(1);
    chk("carrier loss", {7'h00, lvl}, {7'h00, cl});
    if (cl !== lvl)
      test_done();
  endtask : wait_cl

  task automatic rclk_runs(input string what);
    int n;
    logic p;
    n = 0;
    p = rclk;
    repeat (300)
    begin
      tick(1);
      if (rclk !== p)
        n++;
      p = rclk;
    end
    chk(what, 8'h01, {7'h00, n > 4});
  endtask : rclk_runs

  task automatic send_ones(input int n);
    repeat (n)
    begin
      tx_data = 1'b1;
      tx_clk = 1'b1;
      tick(4);
      tx_clk = 1'b0;
      tick(4);
    end
  endtask : send_ones

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    tick(5);
    rst_b = 1'b1;
    tick(2);
    chk("tx enable", 8'h01, {7'h00, tx_oe});
    chk("carrier loss", 8'h01, {7'h00, cl});
    reg_read(8'h7C, 8'h00, "control reset");
    reg_read(8'h31, 8'h00, "info two");
    reg_read(8'h55, 8'h00, "unmapped");
    for (int c = 0; c < 8; c++)
    begin
      reg_write(8'h7C, {c[2:0], 5'h10});
      chk("build out", {5'h00, c[2:0]}, {5'h00, bo});
      chk("gain limit", 8'h01, {7'h00, eq});
      reg_read(8'h7C, {c[2:0], 5'h10}, "control");
    end
    reg_write(8'h31, 8'hFF);
    reg_read(8'h31, 8'h00, "info two read only");
    reg_write(8'h7C, 8'h0E);
    reg_read(8'h7C, 8'h0E, "jitter fields");
    chk("gain limit", 8'h00, {7'h00, eq});
    reg_write(8'h7C, 8'h00);
    // ami: four ones alternate tip and ring
    send_ones(4);
    chk("tip pulses", 8'h02, tip_n[7:0]);
    chk("ring pulses", 8'h02, ring_n[7:0]);
    reg_write(8'h7C, 8'h01);
    send_ones(2);
    chk("tx enable off", 8'h00, {7'h00, tx_oe});
    chk("tx pins", 8'h00, {6'h00, tx_tip, tx_ring});
    reg_write(8'h7C, 8'h00);
    chk("tx enable on", 8'h01, {7'h00, tx_oe});
    line_on = 1'b1;
    wait_cl(1'b0, 200);
    // receive attenuator delays data by half its depth in bits
    tick(2300);
    chk("recovered data", 8'h01, {7'h00, rdata});
    rclk_runs("rclk on line");
    line_on = 1'b0;
    tick(64);
    chk("early loss", 8'h00, {7'h00, cl});
    wait_cl(1'b1, CL_BITS * 32 + 100);
    alt_on = 1'b1;
    rclk_runs("rclk alt rx side");
    alt_on = 1'b0;
    rclk_runs("rclk crystal");
    reg_write(8'h7C, 8'h08);
    alt_on = 1'b1;
    rclk_runs("rclk alt tx side");
    test_done();
  end
endmodule : test_t1_line_interface_control
